// ### hdl/bzcr_pkg.sv
// Purpose: Constants for the bioimpedance configuration and range registers
// Assumes: 200 MHz hclk, AHB-Lite word registers at four times the index
// Notes: Index 0x25 and 0x50 to 0x51 hold bits that have no printed home
package bzcr_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_DRIVE_CFG = 8'h25;
  localparam logic [7:0] IDX_UNDER_THR = 8'h26;
  localparam logic [7:0] IDX_OVER_THR = 8'h27;
  localparam logic [7:0] IDX_RX_CFG = 8'h28;
  localparam logic [7:0] IDX_MUX_CFG = 8'h41;
  localparam logic [7:0] IDX_RES_ERR = 8'h44;
  localparam logic [7:0] IDX_MODE_CTRL = 8'h50;
  localparam logic [7:0] IDX_RANGE_STAT = 8'h51;
  // Reset values
  localparam logic [7:0] RST_DRIVE_CFG = 8'h00;
  localparam logic [7:0] RST_UNDER_THR = 8'h00;
  localparam logic [7:0] RST_OVER_THR = 8'hff;
  localparam logic [7:0] RST_RX_CFG = 8'h00;
  localparam logic [7:0] RST_MUX_CFG = 8'h00;
  localparam logic [7:0] RST_MODE_CTRL = 8'h00;
  // Drive configuration fields
  localparam int DRV_RESET_BIT = 5;
  localparam int DAC_RESET_BIT = 4;
  localparam int STRENGTH_LSB = 2;
  localparam int BANDWIDTH_LSB = 0;
  // Receive configuration fields
  localparam int STBYON_BIT = 4;
  localparam int QPHASE_BIT = 3;
  localparam int IPHASE_BIT = 2;
  localparam int INACHOP_BIT = 1;
  localparam int CHFSEL_BIT = 0;
  localparam logic [7:0] RX_CFG_MASK = 8'h1f;
  // Mux configuration fields
  localparam int LOADSEL_LSB = 6;
  localparam int SELFTEST_BIT = 5;
  localparam int CALONLY_BIT = 2;
  localparam int MUXEN_BIT = 1;
  localparam int CALEN_BIT = 0;
  localparam logic [7:0] MUX_CFG_MASK = 8'he7;
  // Mode control fields
  localparam int DRVMODE_LSB = 0;
  localparam int CMPSEL_BIT = 2;
  localparam logic [7:0] MODE_CTRL_MASK = 8'h07;
  localparam logic [1:0] DRV_MODE_STANDBY = 2'h3;
  // Threshold scaling as left shifts
  localparam int UNDER_SHIFT = 5;
  localparam int OVER_SHIFT = 11;
  localparam int SAMPLE_W = 20;
  // Persistence time of the range detector
  localparam int RANGE_TIME_MS = 128;
  localparam int CLK_MHZ = 200;
  localparam int RANGE_CYCLES = RANGE_TIME_MS * 1000 * CLK_MHZ;
  // AHB transfer type bit for an active transfer
  localparam int HTRANS_ACTIVE_BIT = 1;
endpackage : bzcr_pkg

// ### hdl/bzcr_regs.sv
// Purpose: Bioimpedance front-end configuration and range detector registers
// Assumes: One hclk domain; measurement samples arrive on hclk with a strobe
// Notes: Zero wait state AHB-Lite slave, always OKAY
//
// Behaviour
// - Drive reset disables DAC, shorts feedback
// - DAC reset forces DAC output to zero
// - Strength field selects drive output stage
// - Bandwidth field selects drive amplifier bandwidth
// - Under-range after 128ms within 32x threshold
// - Over-range after 128ms outside 2048x threshold
// - Standby without standby-on disables receive path
// - Quadrature demod clock quadrature unless bit set
// - In-phase demod clock in phase unless set
// - Input amp chop at half converter clock
// - Gain chop divides by 8 or 4
// - Load select picks four self-test resistors
// - Self-test enable connects internal load
// - Factory resistor error readable at 0x44
// - Mux enable low disconnects all pins
// - Calibration-only with calibration enable leaves just calibration pins
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/10ps
module bzcr_regs #(
  parameter int RANGE_LIMIT = bzcr_pkg::RANGE_CYCLES,
  parameter int TIMER_W = 25
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Measurement samples
  input wire logic sample_valid,
  input wire logic signed [bzcr_pkg::SAMPLE_W-1:0] sample_i,
  input wire logic signed [bzcr_pkg::SAMPLE_W-1:0] sample_q,
  // Factory trim
  input wire logic [7:0] selftest_resistor_error,
  // Transmit controls
  output logic dac_enable,
  output logic drive_fb_short,
  output logic dac_zero,
  output logic [1:0] drive_amp_strength,
  output logic [1:0] drive_amp_bandwidth,
  output logic [1:0] transmit_drive_mode,
  // Receive controls
  output logic receive_enable,
  output logic quad_demod_inphase,
  output logic inphase_demod_quad,
  output logic input_amp_chop_enable,
  output logic gain_chop_div4,
  // Self-test and mux controls
  output logic [1:0] selftest_load_select,
  output logic selftest_load_connect,
  output logic electrode_connect,
  output logic calibration_connect,
  // Range status
  output logic under_range_flag,
  output logic over_range_flag
);
  import bzcr_pkg::*;

  logic [7:0] drive_cfg;
  logic [7:0] under_range_threshold;
  logic [7:0] over_range_threshold;
  logic [7:0] receive_phase_chop_config;
  logic [7:0] selftest_mux_config;
  logic [7:0] mode_ctrl;
  logic dp_write;
  logic [7:0] dp_index;
  logic addr_valid;
  logic [7:0] addr_index;
  logic [8:0] addr_map;
  logic [7:0] next_rdata;
  logic [SAMPLE_W-1:0] sample_mag;
  logic under_hold;
  logic over_hold;
  logic [TIMER_W-1:0] under_timer;
  logic [TIMER_W-1:0] over_timer;

  // Magnitude of a signed sample; the most negative value still fits
  function automatic logic [SAMPLE_W-1:0] mag_of(input logic signed [SAMPLE_W-1:0] v);
    mag_of = v[SAMPLE_W-1] ? SAMPLE_W'(-v) : SAMPLE_W'(v);
  endfunction

  // Word index of a byte address, off-word addresses flagged unmapped
  function automatic logic [8:0] index_of(input logic [31:0] a);
    index_of = (a[31:10] == 22'h0 && a[1:0] == 2'h0) ? {1'b1, a[9:2]} : 9'h0;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave
  ////////////////////////////////////////////////////////////////////////

  // Never stalls and never errors
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_valid = hsel && hready && htrans[HTRANS_ACTIVE_BIT];
  // Word decode kept in one net so both phases see the same map
  assign addr_map = index_of(haddr);
  assign addr_index = addr_map[7:0];

  // Address phase capture for the write data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_write <= 1'b0;
      dp_index <= 8'h00;
    end
    else if (hready)
    begin
      dp_write <= addr_valid && hwrite && addr_map[8];
      dp_index <= addr_index;
    end
  end

  // Read mux; unmapped and reserved bits read as zero
  always_comb
  begin
    next_rdata = 8'h00;
    unique case (addr_index)
      IDX_DRIVE_CFG: next_rdata = drive_cfg;
      IDX_UNDER_THR: next_rdata = under_range_threshold;
      IDX_OVER_THR: next_rdata = over_range_threshold;
      IDX_RX_CFG: next_rdata = receive_phase_chop_config;
      IDX_MUX_CFG: next_rdata = selftest_mux_config;
      IDX_RES_ERR: next_rdata = selftest_resistor_error;
      IDX_MODE_CTRL: next_rdata = mode_ctrl;
      IDX_RANGE_STAT: next_rdata = {6'h00, over_range_flag, under_range_flag};
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data is loaded at the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (addr_valid && !hwrite && addr_map[8])
      hrdata <= {24'h00_0000, next_rdata};
    else if (hready)
      hrdata <= 32'h0000_0000;
  end

  // Register writes in the data phase; read-only indices ignore writes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      drive_cfg <= RST_DRIVE_CFG;
      under_range_threshold <= RST_UNDER_THR;
      over_range_threshold <= RST_OVER_THR;
      receive_phase_chop_config <= RST_RX_CFG;
      selftest_mux_config <= RST_MUX_CFG;
      mode_ctrl <= RST_MODE_CTRL;
    end
    else if (dp_write)
    begin
      unique case (dp_index)
        IDX_DRIVE_CFG: drive_cfg <= hwdata[7:0] & 8'h3f;
        IDX_UNDER_THR: under_range_threshold <= hwdata[7:0];
        IDX_OVER_THR: over_range_threshold <= hwdata[7:0];
        IDX_RX_CFG: receive_phase_chop_config <= hwdata[7:0] & RX_CFG_MASK;
        IDX_MUX_CFG: selftest_mux_config <= hwdata[7:0] & MUX_CFG_MASK;
        IDX_MODE_CTRL: mode_ctrl <= hwdata[7:0] & MODE_CTRL_MASK;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit, receive and mux controls
  ////////////////////////////////////////////////////////////////////////

  assign dac_enable = !drive_cfg[DRV_RESET_BIT];
  assign drive_fb_short = drive_cfg[DRV_RESET_BIT];
  assign dac_zero = drive_cfg[DAC_RESET_BIT];
  // strength select; software keeps it matched to current range
  assign drive_amp_strength = drive_cfg[STRENGTH_LSB +: 2];
  assign drive_amp_bandwidth = drive_cfg[BANDWIDTH_LSB +: 2];
  assign transmit_drive_mode = mode_ctrl[DRVMODE_LSB +: 2];

  assign receive_enable = (transmit_drive_mode != DRV_MODE_STANDBY)
    || receive_phase_chop_config[STBYON_BIT];
  assign quad_demod_inphase = receive_phase_chop_config[QPHASE_BIT];
  assign inphase_demod_quad = receive_phase_chop_config[IPHASE_BIT];
  assign input_amp_chop_enable = receive_phase_chop_config[INACHOP_BIT];
  assign gain_chop_div4 = receive_phase_chop_config[CHFSEL_BIT];

  assign selftest_load_select = selftest_mux_config[LOADSEL_LSB +: 2];
  assign selftest_load_connect = selftest_mux_config[SELFTEST_BIT];
  // mux enable gates all pins; calibration-only drops electrodes when calibration enable is set
  assign electrode_connect = selftest_mux_config[MUXEN_BIT]
    && !(selftest_mux_config[CALEN_BIT] && selftest_mux_config[CALONLY_BIT]);
  assign calibration_connect = selftest_mux_config[MUXEN_BIT]
    && selftest_mux_config[CALEN_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Range detector
  ////////////////////////////////////////////////////////////////////////

  assign sample_mag = mode_ctrl[CMPSEL_BIT] ? mag_of(sample_q) : mag_of(sample_i);

  // Window tests held until the next sample decides again
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      under_hold <= 1'b0;
      over_hold <= 1'b0;
    end
    else if (sample_valid)
    begin
      under_hold <= sample_mag <= (SAMPLE_W'(under_range_threshold) << UNDER_SHIFT);
      over_hold <= sample_mag > (SAMPLE_W'(over_range_threshold) << OVER_SHIFT);
    end
  end

  // Duration timers saturate at the limit so the flag stays up
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      under_timer <= '0;
      over_timer <= '0;
    end
    else
    begin
      if (!under_hold)
        under_timer <= '0;
      else if (under_timer != TIMER_W'(RANGE_LIMIT))
        under_timer <= under_timer + 1'b1;
      if (!over_hold)
        over_timer <= '0;
      else if (over_timer != TIMER_W'(RANGE_LIMIT))
        over_timer <= over_timer + 1'b1;
    end
  end

  // Status follows the persistent condition, clearing when it breaks
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      under_range_flag <= 1'b0;
      over_range_flag <= 1'b0;
    end
    else
    begin
      under_range_flag <= under_hold && under_timer == TIMER_W'(RANGE_LIMIT);
      over_range_flag <= over_hold && over_timer == TIMER_W'(RANGE_LIMIT);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  ////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_DRV_RESET: assert property (dp_write && dp_index == IDX_DRIVE_CFG
    |=> drive_fb_short == $past(hwdata[DRV_RESET_BIT]) && dac_enable != drive_fb_short)
    else $error("drive reset outputs disagree");
  AST_DAC_ZERO: assert property (dp_write && dp_index == IDX_DRIVE_CFG
    |=> dac_zero == $past(hwdata[DAC_RESET_BIT]))
    else $error("dac zero does not follow write");
  AST_STRENGTH: assert property (dp_write && dp_index == IDX_DRIVE_CFG
    |=> drive_amp_strength == $past(hwdata[3:2]))
    else $error("strength field not applied");
  AST_BANDWIDTH: assert property (dp_write && dp_index == IDX_DRIVE_CFG
    |=> drive_amp_bandwidth == $past(hwdata[BANDWIDTH_LSB +: 2]))
    else $error("bandwidth field not applied");
  AST_QPHASE: assert property (dp_write && dp_index == IDX_RX_CFG
    |=> quad_demod_inphase == $past(hwdata[QPHASE_BIT]))
    else $error("quadrature path phase not applied");
  AST_IPHASE: assert property (dp_write && dp_index == IDX_RX_CFG
    |=> inphase_demod_quad == $past(hwdata[IPHASE_BIT]))
    else $error("in-phase path phase not applied");
  AST_INA_CHOP: assert property (dp_write && dp_index == IDX_RX_CFG
    |=> input_amp_chop_enable == $past(hwdata[INACHOP_BIT]))
    else $error("input amp chop not applied");
  AST_GAIN_CHOP: assert property (dp_write && dp_index == IDX_RX_CFG
    |=> gain_chop_div4 == $past(hwdata[CHFSEL_BIT]))
    else $error("gain chop select not applied");
  AST_LOAD_SEL: assert property (dp_write && dp_index == IDX_MUX_CFG
    |=> selftest_load_select == $past(hwdata[LOADSEL_LSB +: 2]))
    else $error("load select not applied");
  AST_LOAD_CONNECT: assert property (dp_write && dp_index == IDX_MUX_CFG
    |=> selftest_load_connect == $past(hwdata[SELFTEST_BIT]))
    else $error("load connect not applied");
  AST_STANDBY: assert property (transmit_drive_mode == DRV_MODE_STANDBY
    && !receive_phase_chop_config[STBYON_BIT] |-> !receive_enable)
    else $error("receive on in standby");
  AST_UNDER_TIME: assert property (!under_hold ##1 under_hold [*8]
    |-> !under_range_flag || RANGE_LIMIT < 8)
    else $error("under-range raised too early");
  AST_OVER_SET: assert property (over_hold && over_timer == TIMER_W'(RANGE_LIMIT)
    |=> over_range_flag)
    else $error("over-range not raised at limit");
  AST_RESTART: assert property (sample_valid ##1 !under_hold
    |=> under_timer == '0 && !under_range_flag)
    else $error("under timer not restarted");
  AST_MUX_OFF: assert property (!selftest_mux_config[MUXEN_BIT]
    |-> !electrode_connect && !calibration_connect)
    else $error("pins connected with mux off");
  AST_CAL_ONLY: assert property (selftest_mux_config[2:0] == 3'h7
    |-> calibration_connect && !electrode_connect)
    else $error("calibration-only decode wrong");
  AST_RES_ERR: assert property (addr_valid && !hwrite && haddr == {22'h0, IDX_RES_ERR, 2'b00}
    |=> hrdata[7:0] == $past(selftest_resistor_error))
    else $error("resistor error read wrong");
  AST_UNDER_SET: assert property (under_hold && under_timer == TIMER_W'(RANGE_LIMIT)
    |=> under_range_flag)
    else $error("under-range not raised at limit");
  AST_OVER_RESTART: assert property (sample_valid ##1 !over_hold
    |=> over_timer == '0 && !over_range_flag)
    else $error("over timer not restarted");
endmodule // bzcr_regs

// ### verification/testbench.sv
// Purpose: Self-checking bench for the bioimpedance register bank
// Assumes: AHB-Lite single word transfers, zero-wait slave, short range time
// Notes: Register model is a byte array indexed by register index
`timescale 1ns/10ps
module testbench;
  import bzcr_pkg::*;
  localparam int RL = 20;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, sample_valid;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0] htrans, drive_amp_strength, drive_amp_bandwidth, transmit_drive_mode;
  logic [2:0] hsize;
  logic signed [SAMPLE_W-1:0] sample_i, sample_q;
  logic [7:0] trim;
  logic dac_enable, drive_fb_short, dac_zero, receive_enable, quad_demod_inphase;
  logic inphase_demod_quad, input_amp_chop_enable, gain_chop_div4, selftest_load_connect;
  logic [1:0] selftest_load_select;
  logic electrode_connect, calibration_connect, under_range_flag, over_range_flag;
  logic [7:0] m [0:255];
  logic [7:0] wm [0:255];
  logic [7:0] idx_list [0:9];
  int failures = 0;
  int checked = 0;
  int seed = 76;
  int k;
  logic [7:0] d, r, x, o, ri, rv;

  bzcr_regs #(.RANGE_LIMIT(RL), .TIMER_W(25)) u_bzcr_regs (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .sample_valid(sample_valid), .sample_i(sample_i), .sample_q(sample_q),
    .selftest_resistor_error(trim), .dac_enable(dac_enable),
    .drive_fb_short(drive_fb_short), .dac_zero(dac_zero),
    .drive_amp_strength(drive_amp_strength), .drive_amp_bandwidth(drive_amp_bandwidth),
    .transmit_drive_mode(transmit_drive_mode), .receive_enable(receive_enable),
    .quad_demod_inphase(quad_demod_inphase), .inphase_demod_quad(inphase_demod_quad),
    .input_amp_chop_enable(input_amp_chop_enable), .gain_chop_div4(gain_chop_div4),
    .selftest_load_select(selftest_load_select),
    .selftest_load_connect(selftest_load_connect),
    .electrode_connect(electrode_connect), .calibration_connect(calibration_connect),
    .under_range_flag(under_range_flag), .over_range_flag(over_range_flag)
  );
  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  // Clock, 5 ns period
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Comparison and verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite master; waits on ready, never assumes a latency
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdv = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  // Write through the bus and mirror it in the model
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    bus(1'b1, idx, {$random(seed)} & 32'hffffff00 | {24'h0, v});
    m[idx] = (m[idx] & ~wm[idx]) | (v & wm[idx]);
    @(posedge hclk);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rdv, {24'h0, exp});
  endtask

  // Every control output against the model
  task automatic check_ctrl();
    d = m[IDX_DRIVE_CFG];
    r = m[IDX_RX_CFG];
    x = m[IDX_MUX_CFG];
    o = m[IDX_MODE_CTRL];
    chk({dac_enable, drive_fb_short}, {~d[5], d[5]});
    chk(dac_zero, d[4]);
    chk({drive_amp_strength, drive_amp_bandwidth}, d[3:0]);
    chk(transmit_drive_mode, o[1:0]);
    chk(receive_enable, !(o[1:0] == DRV_MODE_STANDBY && !r[4]));
    chk({quad_demod_inphase, inphase_demod_quad}, r[3:2]);
    chk(input_amp_chop_enable, r[1]);
    chk(gain_chop_div4, r[0]);
    chk({selftest_load_select, selftest_load_connect}, {x[7:6], x[5]});
    chk(electrode_connect, x[1] && !(x[0] && x[2]));
    chk(calibration_connect, x[1] && x[0]);
  endtask

  // One measurement sample, a single-cycle strobe
  task automatic send(input int a, input int b);
    @(posedge hclk);
    sample_valid <= 1'b1;
    sample_i <= a[SAMPLE_W-1:0];
    sample_q <= b[SAMPLE_W-1:0];
    @(posedge hclk);
    sample_valid <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog; the whole run needs well under this span
  initial
  begin
    #100000;
    failures++;
    print_verdict();
  end

  // Main sequence
  initial
  begin
    hresetn = 1'b0;
    {hsel, hwrite, sample_valid} = 3'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    sample_i = '0;
    sample_q = '0;
    trim = 8'($random(seed));
    for (k = 0; k < 256; k++)
    begin
      m[k] = 8'h0;
      wm[k] = 8'h0;
    end
    m[IDX_OVER_THR] = RST_OVER_THR;
    m[IDX_RES_ERR] = trim;
    wm[IDX_DRIVE_CFG] = 8'h3f;
    wm[IDX_UNDER_THR] = 8'hff;
    wm[IDX_OVER_THR] = 8'hff;
    wm[IDX_RX_CFG] = RX_CFG_MASK;
    wm[IDX_MUX_CFG] = MUX_CFG_MASK;
    wm[IDX_MODE_CTRL] = MODE_CTRL_MASK;
    idx_list = '{8'h25, 8'h26, 8'h27, 8'h28, 8'h41, 8'h44, 8'h50, 8'h60, 8'h41, 8'h28};
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, read-only trim and an unmapped word
    for (k = 0; k < 10; k++) rd(idx_list[k], m[idx_list[k]]);
    rd(IDX_RANGE_STAT, 8'h00);
    check_ctrl();
    $display("Reset value test done");
    // Random writes to the listed indices, read-only trim and an unmapped word included
    for (k = 0; k < 60; k++)
    begin
      ri = idx_list[{$random(seed)} % 10];
      rv = 8'($random(seed));
      if (ri == IDX_MUX_CFG && rv[SELFTEST_BIT])
        rv[1:0] = 2'b00;
      wr(ri, rv);
      check_ctrl();
      rd(ri, m[ri]);
    end
    $display("Random register test done");
    // Every drive mode with standby-on both ways
    // chop select 0, stimulus away from converter clock/8
    for (k = 0; k < 8; k++)
    begin
      wr(IDX_RX_CFG, {3'h0, k[2], 4'h0});
      wr(IDX_MODE_CTRL, {6'h0, k[1:0]});
      check_ctrl();
    end
    // Every mux and calibration combination, with each load code
    // self-test rows keep both mux enables low
    for (k = 0; k < 16; k++)
    begin
      wr(IDX_MUX_CFG, {k[1:0], k[3], 2'h0, k[2], k[1:0] & {2{!k[3]}}});
      check_ctrl();
    end
    // strongest stage for the largest drive current range
    wr(IDX_DRIVE_CFG, 8'h0f);
    check_ctrl();
    $display("Decode test done");
    // Under-range, inclusive edge of the window, compare source I
    // Over threshold back to full scale so the random one cannot trip
    wr(IDX_OVER_THR, RST_OVER_THR);
    wr(IDX_UNDER_THR, 8'h01);
    wr(IDX_MODE_CTRL, 8'h00);
    send(-32, 5000);
    repeat (12) @(posedge hclk);
    chk(under_range_flag, 1'b0);
    repeat (15) @(posedge hclk);
    chk({over_range_flag, under_range_flag}, 2'b01);
    rd(IDX_RANGE_STAT, 8'h01);
    send(33, 0);
    repeat (3) @(posedge hclk);
    chk(under_range_flag, 1'b0);
    // Broken condition before timeout restarts the count
    send(5, 0);
    repeat (12) @(posedge hclk);
    send(100, 0);
    send(5, 0);
    repeat (15) @(posedge hclk);
    chk(under_range_flag, 1'b0);
    repeat (10) @(posedge hclk);
    chk(under_range_flag, 1'b1);
    send(1000, 0);
    $display("Under-range test done");
    // Over-range on the Q source, both signs and the exact edge
    wr(IDX_OVER_THR, 8'h01);
    wr(IDX_MODE_CTRL, 8'h04);
    send(0, -3000);
    repeat (30) @(posedge hclk);
    chk({over_range_flag, under_range_flag}, 2'b10);
    rd(IDX_RANGE_STAT, 8'h02);
    send(0, 2048);
    repeat (3) @(posedge hclk);
    chk(over_range_flag, 1'b0);
    send(9000, 2049);
    repeat (30) @(posedge hclk);
    chk(over_range_flag, 1'b1);
    $display("Over-range test done");
    print_verdict();
  end
endmodule // testbench
